// file: src/prmc_pkg.sv
// Shared constants and types of the pin, reset and mode control block
package prmc_pkg;
	// ------------------------------------------------------------
	// Clock rates and timing counts
	// ------------------------------------------------------------
	localparam int SYS_CLK_HZ        = 20_000_000;
	localparam int SELF_CLK_HZ       = 8_000_000;
	localparam int RST_DRIVE_CYCLES  = 34;
	localparam int RST_SAMPLE_CYCLES = 38;
	localparam int BDC_BIT_CYCLES    = 16;
	localparam int BDC_SAMPLE_AT     = 10;
	localparam int BDC_ONE_LOW       = 4;
	localparam int BDC_ZERO_LOW      = 13;
	localparam int GPIO_COUNT        = 55;
	localparam int KBI_LOW_PIN       = 4;
	localparam int OSC_OUT_DEFAULT   = 49;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CAUSE   = 8'h00;
	localparam logic [7:0] OFS_MODE    = 8'h04;
	localparam logic [7:0] OFS_CLKCTL  = 8'h08;
	localparam logic [7:0] OFS_INTSTAT = 8'h0C;
	localparam logic [7:0] OFS_INTMASK = 8'h10;
	localparam logic [7:0] OFS_PINCTL  = 8'h14;
	localparam logic [7:0] OFS_DIR_LO  = 8'h18;
	localparam logic [7:0] OFS_DIR_HI  = 8'h1C;
	localparam logic [7:0] OFS_DAT_LO  = 8'h20;
	localparam logic [7:0] OFS_DAT_HI  = 8'h24;
	localparam logic [7:0] OFS_PULL_LO = 8'h28;
	localparam logic [7:0] OFS_PULL_HI = 8'h2C;
	localparam logic [7:0] OFS_BDC     = 8'h30;
	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int CAUSE_LVD  = 1;
	localparam int CAUSE_ILAD = 3;
	localparam int CAUSE_ILOP = 4;
	localparam int CAUSE_COP  = 5;
	localparam int CAUSE_PIN  = 6;
	localparam int CAUSE_POR  = 7;
	localparam logic [7:0] CAUSE_RESET = 8'h80;
	localparam int INT_RST_DONE = 0;
	localparam int INT_MISMATCH = 1;
	localparam int INT_BDC_RX   = 2;
	localparam int INT_W        = 3;
	localparam int CLK_STOP_SELF = 0;
	localparam int CLK_EXT_CLOCK = 1;
	localparam int CLK_BDC_SELF  = 2;
	localparam int CLK_W         = 3;
	localparam int PIN_DBG_PORT = 0;
	localparam int PIN_DBG_DATA = 1;
	localparam int PIN_IRQ_EN   = 2;
	localparam int PIN_IRQ_RISE = 3;
	localparam int PIN_IRQ_PULL = 4;
	localparam int PIN_KBI_EN   = 5;
	localparam int PIN_KBI_RISE = 6;
	localparam int PIN_W        = 7;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		RST_DRIVE  = 2'b00,
		RST_WAIT   = 2'b01,
		RST_SAMPLE = 2'b11,
		RST_RUN    = 2'b10
	} prmc_rst_state_t;
	typedef enum logic [1:0] {
		BDC_IDLE = 2'b00,
		BDC_TX   = 2'b01,
		BDC_RX   = 2'b11
	} prmc_bdc_state_t;
endpackage

// file: src/prmc_reset_seq.sv
// Reset pin sequencer: drive low, release, resample, record the cause
module prmc_reset_seq
(
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       selfTick,
	input  wire logic [3:0] internalReq,
	input  wire logic       resetPinIn,
	output logic            resetPinOut,
	output logic            resetPinOe,
	output logic            chipReset,
	output logic            causeLoad,
	output logic            pinMismatch,
	output logic [7:0]      causeValue
);
	import prmc_pkg::*;

	prmc_rst_state_t state;
	prmc_rst_state_t next_state;
	logic [5:0]      tickCount;
	logic [7:0]      next_cause;
	logic [7:0]      stateCycles;

	// Internal sources: bit 0 low voltage, 1 watchdog, 2 opcode, 3 address
	wire logic [7:0] reqCause = (8'h01 << CAUSE_LVD) & {8{internalReq[0]}}
		| (8'h01 << CAUSE_COP) & {8{internalReq[1]}}
		| (8'h01 << CAUSE_ILOP) & {8{internalReq[2]}}
		| (8'h01 << CAUSE_ILAD) & {8{internalReq[3]}};
	wire logic driveDone = selfTick
		&& tickCount == 6'(RST_DRIVE_CYCLES - 1);
	wire logic sampleDue = selfTick
		&& tickCount == 6'(RST_SAMPLE_CYCLES - 1);
	wire logic internalCause = |(causeValue
		& ~((8'h01 << CAUSE_PIN) | (8'h01 << CAUSE_POR)));

	assign resetPinOut = 1'b0;
	assign resetPinOe  = state == RST_DRIVE;
	assign chipReset   = state != RST_RUN;
	assign causeLoad   = state == RST_SAMPLE && resetPinIn;
	// An internal reset expects the pin back high; a low sample means a
	// holder outside, which then also counts as a pin reset.
	assign pinMismatch = state == RST_SAMPLE && !resetPinIn
		&& internalCause && !causeValue[CAUSE_PIN];

	always_comb
	begin
		next_state = state;
		next_cause = causeValue;
		case (state)
			RST_RUN:
				if (|internalReq)
				begin
					next_state = RST_DRIVE;
					next_cause = reqCause;
				end
				else if (!resetPinIn)
				begin
					next_state = RST_DRIVE;
					next_cause = 8'h01 << CAUSE_PIN;
				end
			RST_DRIVE:
				if (driveDone)
					next_state = RST_WAIT;
			RST_WAIT:
				if (sampleDue)
					next_state = RST_SAMPLE;
			RST_SAMPLE:
				if (resetPinIn)
					next_state = RST_RUN;
				else
					next_cause = causeValue | (8'h01 << CAUSE_PIN);
			default:
				next_state = RST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			state       <= RST_DRIVE;
			causeValue  <= CAUSE_RESET;
			tickCount   <= 6'h00;
			stateCycles <= 8'h00;
		end
		else
		begin
			state      <= next_state;
			causeValue <= next_cause;
			tickCount  <= (next_state != state) ? 6'h00
				: tickCount + 6'(selfTick);
			stateCycles <= (next_state != state) ? 8'h00
				: stateCycles + 8'(stateCycles != 8'hFF);
		end
	end

	chk_drive_length : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state == RST_DRIVE && next_state == RST_WAIT
		|-> stateCycles >= 8'h51 && stateCycles <= 8'h56)
		else $error("reset pin drive length wrong");
	chk_resample_delay : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state == RST_WAIT && next_state == RST_SAMPLE
		|-> stateCycles >= 8'h5B && stateCycles <= 8'h60)
		else $error("reset pin resample delay wrong");
	chk_release_high : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		$fell(chipReset) |-> $past(resetPinIn) && $past(causeLoad))
		else $error("reset released without a high pin sample");
endmodule

// file: src/prmc_top.sv
// Pin, reset and mode control block with its register slave
//
// Operation
// - Any reset drives the reset pin low 34 self cycles, resamples 38 later.
// - After an internal reset the resampled reset pin must read high.
// - The reset cause is decoded and its flag set in the cause register.
// - The self-clock runs the device during reset startup.
// - Software may pick the self-clock for recovery from stop.
// - With an external clock the oscillator output pin becomes general I/O.
// - Debug pin selects mode during reset, then serves background debug.
// - A debug pin held high at reset release gives normal mode.
// - A debug pin held low at reset release gives active background mode.
// - Each debug link bit lasts 16 debug clock cycles.
// - The debug pin is pseudo open-drain with short driven-high speedup pulses.
// - As an ordinary port bit the debug pin is output only.
// - After reset all shared pins are inputs with pullups disabled.
// - A peripheral drives the output enable; direction bits pick data readback.
// - A pin's pull enable acts whenever the pin is an input, except the oscillator output pin in crystal mode.
// - Upper port A nibble under rising keyboard sense pulls down instead.
// - External interrupt pin on rising edges pulls down instead of up.
// - External interrupt pin on falling edges forces its pullup on.
module prmc_top
#(
	parameter int NUM_GPIO    = prmc_pkg::GPIO_COUNT,
	parameter int OSC_OUT_PIN = prmc_pkg::OSC_OUT_DEFAULT
)
(
	input  wire logic                sys_clk,
	input  wire logic                reset_n,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic [31:0]              hrdata,
	output logic                     hresp,
	output logic                     irq,
	input  wire logic [3:0]          internalResetReq,
	input  wire logic                resetPinIn,
	output logic                     resetPinOut,
	output logic                     resetPinOe,
	output logic                     chipReset,
	input  wire logic                stopRecovery,
	output logic                     selfClockSelect,
	output logic                     oscOutIsGpio,
	input  wire logic                dbgPinIn,
	output logic                     dbgPinOut,
	output logic                     dbgPinOe,
	output logic                     backgroundMode,
	input  wire logic [NUM_GPIO-1:0] gpioIn,
	output logic [NUM_GPIO-1:0]      gpioOut,
	output logic [NUM_GPIO-1:0]      gpioOe,
	output logic [NUM_GPIO-1:0]      gpioPullUp,
	output logic [NUM_GPIO-1:0]      gpioPullDown,
	input  wire logic [NUM_GPIO-1:0] periphOwn,
	input  wire logic [NUM_GPIO-1:0] periphOe,
	input  wire logic [NUM_GPIO-1:0] periphOut,
	output logic                     irqPinPullUp,
	output logic                     irqPinPullDown
);
	import prmc_pkg::*;

	if (NUM_GPIO < 33 || NUM_GPIO > 64)
		$error("NUM_GPIO must lie between 33 and 64");
	if (OSC_OUT_PIN < KBI_LOW_PIN + 4 || OSC_OUT_PIN >= NUM_GPIO)
		$error("OSC_OUT_PIN outside the shared pin range");

	// ------------------------------------------------------------
	// Helpers for split pin registers
	// ------------------------------------------------------------
	function automatic logic [63:0] widen(input logic [NUM_GPIO-1:0] v);
		widen = 64'(v);
	endfunction

	function automatic logic [NUM_GPIO-1:0] merge(
		input logic [NUM_GPIO-1:0] old,
		input logic                upper,
		input logic [31:0]         d);
		logic [63:0] t;
		t = widen(old);
		if (upper)
			t[63:32] = d;
		else
			t[31:0] = d;
		merge = t[NUM_GPIO-1:0];
	endfunction

	// ------------------------------------------------------------
	// Self-clock enable
	// ------------------------------------------------------------
	// Fractional divider: the enable averages the self-clock rate, so
	// single intervals jitter by one system cycle.
	logic [24:0] phase;
	wire logic [25:0] phaseSum = 26'(phase) + 26'(SELF_CLK_HZ);
	wire logic selfTick = phaseSum >= 26'(SYS_CLK_HZ);

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			phase <= 25'h0000000;
		else
			phase <= selfTick ? 25'(phaseSum - 26'(SYS_CLK_HZ))
				: phaseSum[24:0];
	end

	// ------------------------------------------------------------
	// Reset sequencer
	// ------------------------------------------------------------
	logic       causeLoad;
	logic       pinMismatch;
	logic [7:0] causeValue;

	prmc_reset_seq u_reset_seq (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.selfTick    (selfTick),
		.internalReq (internalResetReq),
		.resetPinIn  (resetPinIn),
		.resetPinOut (resetPinOut),
		.resetPinOe  (resetPinOe),
		.chipReset   (chipReset),
		.causeLoad   (causeLoad),
		.pinMismatch (pinMismatch),
		.causeValue  (causeValue)
	);

	// ------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------
	logic                wrPending;
	logic [7:0]          wrAddr;
	logic [CLK_W-1:0]    clkCtl;
	logic [PIN_W-1:0]    pinCtl;
	logic [INT_W-1:0]    intStatus;
	logic [INT_W-1:0]    intMask;
	logic [NUM_GPIO-1:0] dir;
	logic [NUM_GPIO-1:0] portData;
	logic [NUM_GPIO-1:0] pullEn;
	logic                rxBit;
	logic                bdcBusy;

	wire logic addrPhase = hsel && hready && htrans[1];
	wire logic ctrlClear = !reset_n || chipReset;
	wire logic wrClk  = wrPending && wrAddr == OFS_CLKCTL;
	wire logic wrStat = wrPending && wrAddr == OFS_INTSTAT;
	wire logic wrMask = wrPending && wrAddr == OFS_INTMASK;
	wire logic wrPin  = wrPending && wrAddr == OFS_PINCTL;
	wire logic wrDir  = wrPending
		&& (wrAddr == OFS_DIR_LO || wrAddr == OFS_DIR_HI);
	wire logic wrDat  = wrPending
		&& (wrAddr == OFS_DAT_LO || wrAddr == OFS_DAT_HI);
	wire logic wrPull = wrPending
		&& (wrAddr == OFS_PULL_LO || wrAddr == OFS_PULL_HI);
	wire logic wrBdc  = wrPending && wrAddr == OFS_BDC;
	wire logic wrUpper = wrAddr[2];

	wire logic [63:0] dirWide  = widen(dir);
	wire logic [63:0] datWide  = widen(portData);
	wire logic [63:0] pullWide = widen(pullEn);
	// Direction set: the latch; clear: the pin, even if a peripheral owns it
	wire logic [NUM_GPIO-1:0] readBack = (dir & portData)
		| (~dir & gpioIn);
	wire logic [63:0] readWide = widen(readBack);
	wire logic [7:0] rdAddr = haddr[7:0];
	wire logic [31:0] rdMux =
		rdAddr == OFS_CAUSE   ? {24'h000000, causeValue} :
		rdAddr == OFS_MODE    ? {29'h00000000, oscOutIsGpio,
		                         selfClockSelect, backgroundMode} :
		rdAddr == OFS_CLKCTL  ? 32'(clkCtl) :
		rdAddr == OFS_INTSTAT ? 32'(intStatus) :
		rdAddr == OFS_INTMASK ? 32'(intMask) :
		rdAddr == OFS_PINCTL  ? 32'(pinCtl) :
		rdAddr == OFS_DIR_LO  ? dirWide[31:0] :
		rdAddr == OFS_DIR_HI  ? dirWide[63:32] :
		rdAddr == OFS_DAT_LO  ? readWide[31:0] :
		rdAddr == OFS_DAT_HI  ? readWide[63:32] :
		rdAddr == OFS_PULL_LO ? pullWide[31:0] :
		rdAddr == OFS_PULL_HI ? pullWide[63:32] :
		rdAddr == OFS_BDC     ? {30'h00000000, rxBit, bdcBusy} :
		32'h00000000;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			wrPending <= 1'b0;
			wrAddr    <= 8'h00;
			hrdata    <= 32'h00000000;
		end
		else
		begin
			// Only whole-word writes take effect
			wrPending <= addrPhase && hwrite && hsize == 3'h2
				&& haddr[31:8] == 24'h000000;
			wrAddr    <= rdAddr;
			hrdata    <= (addrPhase && !hwrite
				&& haddr[31:8] == 24'h000000) ? rdMux : 32'h00000000;
		end
	end

	// Control registers return to their defaults on every chip reset
	always_ff @(posedge sys_clk)
	begin
		if (ctrlClear)
		begin
			clkCtl   <= CLK_W'(CTRL_RESET);
			pinCtl   <= PIN_W'(CTRL_RESET);
			dir      <= NUM_GPIO'(CTRL_RESET);
			portData <= NUM_GPIO'(CTRL_RESET);
			pullEn   <= NUM_GPIO'(CTRL_RESET);
		end
		else
		begin
			if (wrClk)
				clkCtl <= hwdata[CLK_W-1:0];
			if (wrPin)
				pinCtl <= hwdata[PIN_W-1:0];
			if (wrDir)
				dir <= merge(dir, wrUpper, hwdata);
			if (wrDat)
				portData <= merge(portData, wrUpper, hwdata);
			if (wrPull)
				pullEn <= merge(pullEn, wrUpper, hwdata);
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic bdcRxDone;
	wire logic [INT_W-1:0] intEvents = {bdcRxDone, pinMismatch, causeLoad};
	wire logic [INT_W-1:0] intClear = wrStat ? hwdata[INT_W-1:0]
		: INT_W'(CTRL_RESET);
	// A new event outranks a clear landing in the same cycle
	wire logic [INT_W-1:0] next_intStatus = (intStatus & ~intClear)
		| intEvents;

	assign irq = |(intStatus & intMask);

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			intStatus <= INT_W'(CTRL_RESET);
			intMask   <= INT_W'(CTRL_RESET);
		end
		else
		begin
			intStatus <= next_intStatus;
			if (wrMask)
				intMask <= hwdata[INT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Clock source and mode select
	// ------------------------------------------------------------
	assign selfClockSelect = chipReset
		|| (stopRecovery && clkCtl[CLK_STOP_SELF]);
	assign oscOutIsGpio = clkCtl[CLK_EXT_CLOCK];

	// The level is followed while in reset and freezes at release
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			backgroundMode <= 1'b0;
		else if (chipReset)
			backgroundMode <= !dbgPinIn;
	end

	// ------------------------------------------------------------
	// Background debug bit timing
	// ------------------------------------------------------------
	prmc_bdc_state_t bdcState;
	prmc_bdc_state_t next_bdcState;
	logic [3:0]      bdcCount;
	logic            txBit;
	logic            dbgPrev;

	wire logic dbgPortMode = !chipReset && pinCtl[PIN_DBG_PORT]
		&& !backgroundMode;
	wire logic bdcOwnsPin = !chipReset && !dbgPortMode;
	wire logic bdcTick = clkCtl[CLK_BDC_SELF] ? selfTick : 1'b1;
	wire logic bdcLast = bdcTick
		&& bdcCount == 4'(BDC_BIT_CYCLES - 1);
	wire logic [3:0] lowLen = txBit ? 4'(BDC_ONE_LOW) : 4'(BDC_ZERO_LOW);
	wire logic bdcTxing = bdcState == BDC_TX;
	wire logic bdcDriveLow = bdcTxing && bdcCount < lowLen;
	// One debug clock of active high sharpens the rising edge
	wire logic bdcSpeedup = bdcTxing && bdcCount == lowLen;
	wire logic hostFall = dbgPrev && !dbgPinIn;
	wire logic txStart = wrBdc && bdcState == BDC_IDLE && bdcOwnsPin;

	assign bdcBusy   = bdcState != BDC_IDLE;
	assign bdcRxDone = bdcState == BDC_RX && bdcLast;
	assign dbgPinOe  = !chipReset
		&& (dbgPortMode || bdcDriveLow || bdcSpeedup);
	assign dbgPinOut = dbgPortMode ? pinCtl[PIN_DBG_DATA] : bdcSpeedup;

	always_comb
	begin
		next_bdcState = bdcState;
		case (bdcState)
			BDC_IDLE:
				if (txStart)
					next_bdcState = BDC_TX;
				else if (hostFall && bdcOwnsPin)
					next_bdcState = BDC_RX;
			BDC_TX, BDC_RX:
				if (bdcLast)
					next_bdcState = BDC_IDLE;
			default:
				next_bdcState = BDC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (ctrlClear)
		begin
			bdcState <= BDC_IDLE;
			bdcCount <= 4'h0;
			txBit    <= 1'b0;
			rxBit    <= 1'b0;
			dbgPrev  <= 1'b1;
		end
		else
		begin
			bdcState <= next_bdcState;
			bdcCount <= (next_bdcState != bdcState) ? 4'h0
				: bdcCount + 4'(bdcTick);
			dbgPrev  <= dbgPinIn;
			if (txStart)
				txBit <= hwdata[0];
			if (bdcState == BDC_RX && bdcTick
				&& bdcCount == 4'(BDC_SAMPLE_AT))
				rxBit <= dbgPinIn;
		end
	end

	// ------------------------------------------------------------
	// Shared pins, pulls and the external interrupt pin
	// ------------------------------------------------------------
	// Crystal mode leaves the oscillator output pin to the oscillator
	wire logic [NUM_GPIO-1:0] oscBlock = clkCtl[CLK_EXT_CLOCK]
		? NUM_GPIO'(0) : NUM_GPIO'(1) << OSC_OUT_PIN;
	wire logic [NUM_GPIO-1:0] pinDrive = (periphOwn & periphOe)
		| (~periphOwn & dir);
	wire logic [NUM_GPIO-1:0] pullActive = pullEn & ~pinDrive
		& ~oscBlock;
	wire logic [NUM_GPIO-1:0] kbiDown =
		(pinCtl[PIN_KBI_EN] && pinCtl[PIN_KBI_RISE])
		? NUM_GPIO'(4'hF) << KBI_LOW_PIN : NUM_GPIO'(0);

	assign gpioOe = pinDrive & ~oscBlock;
	assign gpioOut = (periphOwn & periphOut) | (~periphOwn & portData);
	assign gpioPullUp = pullActive & ~kbiDown;
	assign gpioPullDown = pullActive & kbiDown;
	assign irqPinPullUp = pinCtl[PIN_IRQ_EN]
		&& !pinCtl[PIN_IRQ_RISE];
	assign irqPinPullDown = pinCtl[PIN_IRQ_EN] && pinCtl[PIN_IRQ_RISE]
		&& pinCtl[PIN_IRQ_PULL];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_mode_capture : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		$fell(chipReset) |-> backgroundMode == !$past(dbgPinIn))
		else $error("mode not taken from debug pin at release");
	chk_debug_reset_input : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		chipReset |-> !dbgPinOe ##1 (chipReset || !bdcBusy))
		else $error("debug pin driven while in reset");
	chk_port_output : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		!chipReset && pinCtl[PIN_DBG_PORT] && !backgroundMode
		|-> dbgPinOe && dbgPinOut == pinCtl[PIN_DBG_DATA] && !bdcBusy)
		else $error("debug port bit not output only");
	chk_bit_time : assert property (
		@(posedge sys_clk) disable iff (ctrlClear)
		$rose(bdcBusy) && !clkCtl[CLK_BDC_SELF]
		|-> bdcBusy[*8] ##1 bdcBusy[*8] ##1 !bdcBusy)
		else $error("debug bit time not 16 cycles");
	chk_speedup_pulse : assert property (
		@(posedge sys_clk) disable iff (ctrlClear)
		$rose(bdcTxing) && txBit && !clkCtl[CLK_BDC_SELF]
		|-> (dbgPinOe && !dbgPinOut)[*4] ##1 (dbgPinOe && dbgPinOut)
		##1 !dbgPinOe)
		else $error("one bit lacks low time or speedup pulse");
	chk_pins_after_reset : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		$fell(chipReset) |-> dir == '0 && pullEn == '0
		&& (gpioPullUp | gpioPullDown) == '0)
		else $error("pins not inputs without pulls after reset");
	chk_pull_input_only : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		((gpioPullUp | gpioPullDown) & gpioOe) == '0)
		else $error("pull device active on a driven pin");
	chk_kbi_pulldown : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		pinCtl[PIN_KBI_EN] && pinCtl[PIN_KBI_RISE]
		|-> gpioPullUp[KBI_LOW_PIN+3:KBI_LOW_PIN] == 4'h0)
		else $error("pullup on rising keyboard pin");
	chk_irq_pull : assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		pinCtl[PIN_IRQ_EN] |-> irqPinPullUp != pinCtl[PIN_IRQ_RISE]
		&& !(irqPinPullUp && irqPinPullDown))
		else $error("interrupt pin pull direction wrong");
endmodule

// file: test/prmc_partner.sv
// Far side model: reset source and debug host on pulled-up pins
module prmc_partner
(
	input  wire logic resetPinOe,
	input  wire logic resetPinOut,
	input  wire logic dbgPinOe,
	input  wire logic dbgPinOut,
	input  wire logic hostDbgLow,
	input  wire logic hostRstLow,
	output logic      resetPinIn,
	output logic      dbgPinIn
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released pins settle to their pullup, never to the last value
	assign resetPinIn = resetPinOe ? resetPinOut : !hostRstLow;
	assign dbgPinIn = dbgPinOe ? dbgPinOut : !hostDbgLow;
endmodule

// file: test/tb.sv
// Self-checking bench of the pin, reset and mode control block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import prmc_pkg::*;
	logic        sys_clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        hsel = 1'h0, hwrite = 1'h0, stopRecovery = 1'h0;
	logic        hostDbgLow = 1'h0, hostRstLow = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
	logic [3:0]  internalResetReq = 4'h0;
	logic [54:0] gpioIn = '0, periphOwn = '0, periphOe = '0;
	logic [54:0] periphOut = '0, gpioOut, gpioOe, gpioPullUp, gpioPullDown;
	logic        hreadyout, hresp, irq, resetPinIn, resetPinOut, resetPinOe;
	logic        chipReset, selfClockSelect, oscOutIsGpio, dbgPinIn;
	logic        dbgPinOut, dbgPinOe, backgroundMode;
	logic        irqPinPullUp, irqPinPullDown;
	wire         hready = hreadyout;
	int          fails = 0, testsRun = 0, cyc = 0;
	int          oeCnt = 0, lowCnt = 0, hiCnt = 0;
	int          oe0 = 0, lo0 = 0, hi0 = 0;

	prmc_top u_dut (.*);
	prmc_partner u_far (.*);

	initial forever #25 sys_clk = !sys_clk;

	// Pin activity is counted at every rising edge; the run is cut short on a hang
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (reset_n && resetPinOe) oeCnt <= oeCnt + 1;
		if (dbgPinOe && !dbgPinOut) lowCnt <= lowCnt + 1;
		if (dbgPinOe && dbgPinOut) hiCnt <= hiCnt + 1;
		if (cyc == 3000)
		begin
			fails++;
			complete_run();
		end
	end

	task automatic check(input string nm, input logic [63:0] seen, exp);
		testsRun++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'h1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge sys_clk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'h1);
		rd = hrdata;
		#1;
	endtask

	task automatic rdChk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		check(nm, rd, e);
	endtask

	// Bus writes to control registers are ignored until the sequence ends
	task automatic waitRun();
		repeat (400) if (chipReset === 1'h1) @(posedge sys_clk);
		#1;
	endtask

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'h1;
		waitRun();
		check("drive", oeCnt >= 83 && oeCnt <= 86, 1);
		rdChk("cause", OFS_CAUSE, 32'h80);
		rdChk("stat", OFS_INTSTAT, 32'h1);
		check("oe", |{gpioOe, gpioPullUp, gpioPullDown}, 0);
		check("bus", {hresp, hreadyout, resetPinOut}, 3'h2);
		check("mode", backgroundMode, 0);
		rdChk("gap", 8'h3C, 32'h0);
		bus(1'h1, OFS_INTSTAT, 32'h1);
		rdChk("w1c", OFS_INTSTAT, 32'h0);
		for (int b = 0; b < 2; b++)
		begin
			lo0 = lowCnt;
			hi0 = hiCnt;
			bus(1'h1, OFS_BDC, b);
			repeat (20) @(posedge sys_clk);
			check("low", lowCnt - lo0, b ? BDC_ONE_LOW : BDC_ZERO_LOW);
			check("kick", hiCnt - hi0, 1);
		end
		hostDbgLow <= 1'h1;
		repeat (4) @(posedge sys_clk);
		hostDbgLow <= 1'h0;
		repeat (20) @(posedge sys_clk);
		rdChk("rx", OFS_BDC, 32'h2);
		bus(1'h1, OFS_INTMASK, 32'h4);
		check("irqOn", irq, 1);
		bus(1'h1, OFS_INTMASK, 32'h0);
		check("irqMask", irq, 0);
		bus(1'h1, OFS_INTSTAT, 32'h4);
		bus(1'h1, OFS_INTMASK, 32'h4);
		check("irqClr", irq, 0);
		bus(1'h1, OFS_PINCTL, 32'h3);
		check("port", {dbgPinOe, dbgPinOut}, 2'h3);
		bus(1'h1, OFS_PINCTL, 32'h1);
		check("port", {dbgPinOe, dbgPinOut}, 2'h2);
		bus(1'h1, OFS_PULL_LO, 32'hFFFFFFFF);
		bus(1'h1, OFS_PINCTL, 32'h60);
		check("kbi", {gpioPullDown[7:0], gpioPullUp[7:0]}, 16'hF00F);
		bus(1'h1, OFS_PINCTL, 32'h1C);
		check("irqPd", {irqPinPullDown, irqPinPullUp}, 2'h2);
		bus(1'h1, OFS_PINCTL, 32'h4);
		check("irqPu", {irqPinPullDown, irqPinPullUp}, 2'h1);
		@(posedge sys_clk);
		periphOwn <= 55'h1;
		periphOe <= 55'h0;
		periphOut <= 55'h1;
		gpioIn <= '1;
		stopRecovery <= 1'h1;
		bus(1'h1, OFS_DIR_LO, 32'h1);
		check("own", {gpioPullUp[1:0], gpioOe[1:0], gpioOut[0]}, 5'h19);
		rdChk("dat", OFS_DAT_LO, 32'hFFFFFFFE);
		bus(1'h1, OFS_CLKCTL, 32'h7);
		check("clk", {selfClockSelect, oscOutIsGpio}, 2'h3);
		rdChk("modeReg", OFS_MODE, 32'h6);
		// Debug bit on the self tick: low and speedup stretch with the tick
		lo0 = lowCnt;
		hi0 = hiCnt;
		bus(1'h1, OFS_BDC, 32'h1);
		repeat (60) @(posedge sys_clk);
		check("slowLow", (lowCnt - lo0) inside {[9:11]}, 1);
		check("slowKick", (hiCnt - hi0) inside {[2:3]}, 1);
		@(posedge sys_clk);
		hostDbgLow <= 1'h1;
		internalResetReq <= 4'h2;
		stopRecovery <= 1'h0;
		periphOwn <= '0;
		@(posedge sys_clk);
		internalResetReq <= 4'h0;
		#1;
		oe0 = oeCnt;
		check("self", selfClockSelect, 1);
		waitRun();
		check("drive2", (oeCnt - oe0) inside {[83:86]}, 1);
		rdChk("cause2", OFS_CAUSE, 32'h20);
		check("bg", backgroundMode, 1);
		check("oe2", |{gpioOe, gpioPullUp, gpioPullDown}, 0);
		// Internal reset while the pin is held low through the resample
		@(posedge sys_clk);
		internalResetReq <= 4'h1;
		hostDbgLow <= 1'h0;
		@(posedge sys_clk);
		internalResetReq <= 4'h0;
		repeat (100) @(posedge sys_clk);
		hostRstLow <= 1'h1;
		repeat (150) @(posedge sys_clk);
		hostRstLow <= 1'h0;
		waitRun();
		check("bg3", backgroundMode, 0);
		rdChk("cause3", OFS_CAUSE, 32'h42);
		rdChk("mism", OFS_INTSTAT, 32'h3);
		complete_run();
	end
endmodule
